// ### hdl/dio_pkg.sv
// Package: register map, widths and reset values of the dual port block
package dio_pkg;
    localparam int DIO_WIDTH = 8;
    localparam int DIO_ADDR_W = 4;
    // Register offsets
    localparam logic [3:0] FIRST_PORT_PIN_LEVELS = 4'h0;
    localparam logic [3:0] FIRST_PORT_OUTPUT_REG = 4'h1;
    localparam logic [3:0] FIRST_PORT_DIRECTION_REG = 4'h2;
    localparam logic [3:0] FIRST_PORT_OPENDRAIN_REG = 4'h3;
    localparam logic [3:0] FIRST_PORT_PULLUP_REG = 4'h4;
    localparam logic [3:0] FIRST_PORT_MODE_REG = 4'h5;
    localparam logic [3:0] PORT_C_PIN_LEVELS = 4'h8;
    localparam logic [3:0] PORT_C_OUTPUT_VALUE = 4'h9;
    localparam logic [3:0] PORT_C_DIRECTION = 4'ha;
    // Reset values
    localparam logic [7:0] DIO_RESET_BYTE = 8'h00;
    localparam logic [7:0] DIO_UNMAPPED_READ = 8'h00;
endpackage

// ### hdl/dio_sync.sv
// Two-flop synchroniser for a pin bus
`timescale 1ns/1ps
`default_nettype none
module dio_sync
    import dio_pkg::*;
#(
    parameter int WIDTH = DIO_WIDTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } dio_sync_state_type;

    dio_sync_state_type state;
    dio_sync_state_type next_state;

    always_comb begin
        next_state.stage1 = async_in;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stage2;
endmodule
`default_nettype wire

// ### hdl/dio_pin_ctrl.sv
// Per-pin drive, enable and pull-up logic of the first port
`timescale 1ns/1ps
`default_nettype none
module dio_pin_ctrl
    import dio_pkg::*;
#(
    parameter int WIDTH = DIO_WIDTH
) (
    input wire logic [WIDTH-1:0] dir,
    input wire logic [WIDTH-1:0] out_val,
    input wire logic [WIDTH-1:0] open_drain,
    input wire logic [WIDTH-1:0] pullup_sel,
    input wire logic [WIDTH-1:0] analog_sel,
    input wire logic [WIDTH-1:0] func_en,
    input wire logic [WIDTH-1:0] func_dir,
    input wire logic [WIDTH-1:0] func_out,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe_n,
    output logic [WIDTH-1:0] pullup_en,
    output logic [WIDTH-1:0] in_buf_en
);
    // ==========================================
    // Per-pin priority and drive
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            logic drive_dir;
            logic drive_val;
            logic drives;
            assign drive_dir = func_en[i] ? func_dir[i] : dir[i];
            assign drive_val = func_en[i] ? func_out[i] : out_val[i];
            // Open drain only pulls low
            assign drives = !analog_sel[i] && drive_dir && (!open_drain[i] || !drive_val);
            assign pin_o[i] = open_drain[i] ? 1'b0 : drive_val;
            assign pin_oe_n[i] = !drives;
            assign pullup_en[i] = !analog_sel[i] && pullup_sel[i]
                && (!drive_dir || (open_drain[i] && drive_val));
            assign in_buf_en[i] = !analog_sel[i];
        end
    endgenerate
endmodule
`default_nettype wire

// ### hdl/dio_top.sv
// Dual 8-bit general purpose digital port with register access
`timescale 1ns/1ps
`default_nettype none
// Contract
// - First port direction 1 drives, 0 inputs
// - Reset clears first port direction
// - First port levels read raw, read-only
// - Input buffer stays on when output
// - Output bits driven when direction set; reset 0
// - Open drain: low for 0, float for 1
// - Reset clears open-drain bits
// - Per-pin pull-up select, reset 0
// - Pull-up only input or floating open-drain
// - Input buffer off only in analog mode
// - Second port direction 1 drives output
// - Reset clears second port registers
// - Second port output register drives pins
// - Second port levels read raw, read-only
// - Second port eight bits, 7 to 0
// - Analog beats function beats digital
module dio_top
    import dio_pkg::*;
#(
    parameter int WIDTH = DIO_WIDTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [DIO_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [WIDTH-1:0] first_port_pin_i,
    output logic [WIDTH-1:0] first_port_pin_o,
    output logic [WIDTH-1:0] first_port_pin_oe_n,
    output logic [WIDTH-1:0] first_port_pullup_en,
    output logic [WIDTH-1:0] first_port_in_buf_en,
    input wire logic [WIDTH-1:0] first_port_func_en,
    input wire logic [WIDTH-1:0] first_port_func_dir,
    input wire logic [WIDTH-1:0] first_port_func_out,
    input wire logic [WIDTH-1:0] second_port_pin_i,
    output logic [WIDTH-1:0] second_port_pin_o,
    output logic [WIDTH-1:0] second_port_pin_oe_n
);
    // ==========================================
    // State
    typedef struct packed {
        logic [WIDTH-1:0] first_port_output_reg;
        logic [WIDTH-1:0] first_port_direction_reg;
        logic [WIDTH-1:0] first_port_opendrain_reg;
        logic [WIDTH-1:0] first_port_pullup_reg;
        logic [WIDTH-1:0] first_port_analog_reg;
        logic [WIDTH-1:0] port_c_output_value;
        logic [WIDTH-1:0] port_c_direction;
        logic [7:0] rdata;
    } dio_state_type;

    dio_state_type state;
    dio_state_type next_state;
    logic [WIDTH-1:0] first_port_pin_levels;
    logic [WIDTH-1:0] port_c_pin_levels;
    logic [7:0] read_mux;

    // ==========================================
    // Pin synchronisers
    dio_sync #(.WIDTH(WIDTH)) u_sync_first (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(first_port_pin_i),
        .sync_out(first_port_pin_levels)
    );

    dio_sync #(.WIDTH(WIDTH)) u_sync_second (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(second_port_pin_i),
        .sync_out(port_c_pin_levels)
    );

    // ==========================================
    // First port pin control
    dio_pin_ctrl #(.WIDTH(WIDTH)) u_pin_ctrl (
        .dir(state.first_port_direction_reg),
        .out_val(state.first_port_output_reg),
        .open_drain(state.first_port_opendrain_reg),
        .pullup_sel(state.first_port_pullup_reg),
        .analog_sel(state.first_port_analog_reg),
        .func_en(first_port_func_en),
        .func_dir(first_port_func_dir),
        .func_out(first_port_func_out),
        .pin_o(first_port_pin_o),
        .pin_oe_n(first_port_pin_oe_n),
        .pullup_en(first_port_pullup_en),
        .in_buf_en(first_port_in_buf_en)
    );

    // ==========================================
    // Second port drive
    assign second_port_pin_o = state.port_c_output_value;
    assign second_port_pin_oe_n = ~state.port_c_direction;

    // ==========================================
    // Read mux
    always_comb begin
        read_mux = DIO_UNMAPPED_READ;
        case (reg_addr)
            FIRST_PORT_PIN_LEVELS: read_mux = 8'(first_port_pin_levels & state.first_port_direction_reg
                | first_port_pin_levels & ~state.first_port_direction_reg);
            FIRST_PORT_OUTPUT_REG: read_mux = 8'(state.first_port_output_reg);
            FIRST_PORT_DIRECTION_REG: read_mux = 8'(state.first_port_direction_reg);
            FIRST_PORT_OPENDRAIN_REG: read_mux = 8'(state.first_port_opendrain_reg);
            FIRST_PORT_PULLUP_REG: read_mux = 8'(state.first_port_pullup_reg);
            FIRST_PORT_MODE_REG: read_mux = 8'(state.first_port_analog_reg);
            PORT_C_PIN_LEVELS: read_mux = 8'(port_c_pin_levels);
            PORT_C_OUTPUT_VALUE: read_mux = 8'(state.port_c_output_value);
            PORT_C_DIRECTION: read_mux = 8'(state.port_c_direction);
            default: read_mux = DIO_UNMAPPED_READ;
        endcase
    end

    // ==========================================
    // Register writes
    always_comb begin
        next_state = state;
        next_state.rdata = reg_read ? read_mux : DIO_RESET_BYTE;
        if (reg_write) begin
            case (reg_addr)
                FIRST_PORT_OUTPUT_REG: next_state.first_port_output_reg = reg_wdata[WIDTH-1:0];
                FIRST_PORT_DIRECTION_REG: next_state.first_port_direction_reg = reg_wdata[WIDTH-1:0];
                FIRST_PORT_OPENDRAIN_REG: next_state.first_port_opendrain_reg = reg_wdata[WIDTH-1:0];
                FIRST_PORT_PULLUP_REG: next_state.first_port_pullup_reg = reg_wdata[WIDTH-1:0];
                FIRST_PORT_MODE_REG: next_state.first_port_analog_reg = reg_wdata[WIDTH-1:0];
                PORT_C_OUTPUT_VALUE: next_state.port_c_output_value = reg_wdata[WIDTH-1:0];
                PORT_C_DIRECTION: next_state.port_c_direction = reg_wdata[WIDTH-1:0];
                default: next_state = next_state;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;
endmodule
`default_nettype wire

// ### test/dio_props.sv
// Checker of the port outputs
`timescale 1ns/1ps
`default_nettype none
module dio_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] first_port_pin_oe_n,
    input wire logic [7:0] first_port_pullup_en,
    input wire logic [7:0] first_port_in_buf_en,
    input wire logic [7:0] first_port_func_en,
    input wire logic [7:0] second_port_pin_o,
    input wire logic [7:0] second_port_pin_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ========================================
    // Properties
    property p_dir; reg_write && reg_addr == 4'ha |=> second_port_pin_oe_n == ~$past(reg_wdata); endproperty
    property p_out; reg_write && reg_addr == 4'h9 |=> second_port_pin_o == $past(reg_wdata); endproperty
    property p_rst2; $rose(rst_n) |-> second_port_pin_oe_n == 8'hff && second_port_pin_o == 8'h00; endproperty
    property p_rst1;
        $rose(rst_n) && first_port_func_en == 8'h00 |-> first_port_pin_oe_n == 8'hff && first_port_pullup_en == 8'h00;
    endproperty
    property p_pull; (first_port_pullup_en & ~first_port_pin_oe_n) == 8'h00; endproperty
    property p_abuf; (~first_port_in_buf_en & (~first_port_pin_oe_n | first_port_pullup_en)) == 8'h00; endproperty
    property p_ro; reg_write && reg_addr[2:0] == 3'h0 |=> $stable(second_port_pin_o) && $stable(second_port_pin_oe_n);
    endproperty
    property p_rd; reg_read && reg_addr == 4'h9 |=> reg_rdata == $past(second_port_pin_o); endproperty
    a_dir: assert property (p_dir) else $error("direction not applied");
    a_out: assert property (p_out) else $error("output not applied");
    a_rst2: assert property (p_rst2) else $error("second port not reset");
    a_rst1: assert property (p_rst1) else $error("first port not reset");
    a_pull: assert property (p_pull) else $error("pull-up while driving");
    a_abuf: assert property (p_abuf) else $error("analog pin active");
    a_ro: assert property (p_ro) else $error("input write changed pins");
    a_rd: assert property (p_rd) else $error("readback wrong");
    c_rd: cover property (reg_read && reg_addr == 4'h8);
    c_pu: cover property (first_port_pullup_en != 8'h00);
    c_an: cover property (first_port_in_buf_en != 8'hff);
endmodule
bind dio_top dio_props i_dio_props (
    .clk(clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .first_port_pin_oe_n(first_port_pin_oe_n),
    .first_port_pullup_en(first_port_pullup_en),
    .first_port_in_buf_en(first_port_in_buf_en),
    .first_port_func_en(first_port_func_en),
    .second_port_pin_o(second_port_pin_o),
    .second_port_pin_oe_n(second_port_pin_oe_n)
);
`default_nettype wire

// ### test/dio_pins.sv
// Outside circuit that resolves the pin levels
`timescale 1ns/1ps
`default_nettype none
module dio_pins (
    input wire logic [7:0] b_o,
    input wire logic [7:0] b_oe_n,
    input wire logic [7:0] b_pu,
    input wire logic [7:0] b_ext,
    input wire logic [7:0] c_o,
    input wire logic [7:0] c_oe_n,
    input wire logic [7:0] c_ext,
    output logic [7:0] b_lvl,
    output logic [7:0] c_lvl
);
    // Device drive wins, then pull-up, then weak outside source
    assign b_lvl = (~b_oe_n & b_o) | (b_oe_n & (b_pu | b_ext));
    assign c_lvl = (~c_oe_n & c_o) | (c_oe_n & c_ext);
endmodule
`default_nettype wire

// ### test/test_dual_digital_io_ports.sv
// Testbench of the dual port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module test_dual_digital_io_ports;
    logic clk = 0, rst_n = 0, reg_write = 0, reg_read = 0, rd_seen = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [3:0] regs[8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'ha};
    logic [7:0] reg_wdata = 8'h00, reg_rdata, pb_o, pb_oe_n, pb_pu, pb_buf, pb_lvl, pc_o, pc_oe_n, pc_lvl;
    logic [7:0] f_en = 8'h00, f_dir = 8'h00, f_out = 8'h00, ext_b = 8'h00, ext_c = 8'h00;
    logic [7:0] d, o, od, pu, drv, e;
    logic [7:0] exp_q[$];
    int errors = 0, tests_run = 0;
    dio_top i_dio_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .first_port_pin_i(pb_lvl), .first_port_pin_o(pb_o),
        .first_port_pin_oe_n(pb_oe_n), .first_port_pullup_en(pb_pu), .first_port_in_buf_en(pb_buf),
        .first_port_func_en(f_en), .first_port_func_dir(f_dir), .first_port_func_out(f_out),
        .second_port_pin_i(pc_lvl), .second_port_pin_o(pc_o), .second_port_pin_oe_n(pc_oe_n));
    dio_pins i_dio_pins (.b_o(pb_o), .b_oe_n(pb_oe_n), .b_pu(pb_pu), .b_ext(ext_b), .c_o(pc_o),
        .c_oe_n(pc_oe_n), .c_ext(ext_c), .b_lvl(pb_lvl), .c_lvl(pc_lvl));
    initial forever #5 clk = ~clk;
    // ========================================
    // Read data monitor
    always @(posedge clk) rd_seen <= reg_read;
    always @(negedge clk) if (rd_seen) begin
        e = exp_q.pop_front();
        `CHK(reg_rdata, e)
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk) {reg_write, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge clk) reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk) {reg_read, reg_addr} <= {1'b1, a};
        exp_q.push_back(v);
        @(posedge clk) reg_read <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        give_verdict;
    end
    // ========================================
    // Main sequence
    initial begin
        void'($urandom(72));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        foreach (regs[i]) rd(regs[i], 8'h00);
        repeat (4) begin
            d = 8'($urandom);
            o = 8'($urandom);
            ext_c <= 8'($urandom);
            wr(4'h9, o);
            wr(4'ha, d);
            wr(4'h8, ~o);
            repeat (3) @(posedge clk);
            rd(4'h8, (d & o) | (~d & ext_c));
            rd(4'h9, o);
            rd(4'ha, d);
        end
        repeat (4) begin
            d = 8'($urandom);
            o = 8'($urandom);
            od = 8'($urandom);
            pu = 8'($urandom);
            ext_b <= 8'($urandom);
            wr(4'h1, o);
            wr(4'h2, d);
            wr(4'h3, od);
            wr(4'h4, pu);
            wr(4'h0, ~d);
            drv = d & ~(od & o);
            repeat (3) @(posedge clk);
            rd(4'h0, (drv & o) | (~drv & (pu | ext_b)));
            rd(4'h2, d);
            @(negedge clk);
            `CHK(pb_pu, pu & ~drv)
            `CHK(pb_oe_n, ~drv)
        end
        f_en <= 8'($urandom);
        f_dir <= 8'($urandom);
        f_out <= 8'($urandom);
        wr(4'h3, 8'h00);
        @(negedge clk);
        drv = (f_en & f_dir) | (~f_en & d);
        `CHK(pb_oe_n, ~drv)
        `CHK(pb_o & drv, ((f_en & f_out) | (~f_en & o)) & drv)
        wr(4'h5, 8'hff);
        @(negedge clk);
        `CHK(pb_buf, 8'h00)
        `CHK(pb_oe_n, 8'hff)
        repeat (3) @(posedge clk);
        give_verdict;
    end
endmodule
`default_nettype wire
